// >>> gated_timer_counter_core.v
// gated 16-bit timer counter core with source select, prescaler and sync bypass
`timescale 1ns/10ps
`include "timer_consts.vh"
module gated_timer_counter_core #(
  parameter OWN_INDEX = 0
) (
  // clock and reset
  input  wire       clock,
  input  wire       rst_b,
  // register port
  input  wire [2:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_wr,
  input  wire       reg_rd,
  output reg  [7:0] reg_rdata,
  // count sources
  input  wire       count_input_pin,
  input  wire       high_freq_internal_osc,
  input  wire       low_freq_internal_osc,
  input  wire       mid_freq_internal_osc,
  input  wire       secondary_oscillator,
  input  wire       reference_clock_out,
  input  wire       timer_zero_overflow,
  input  wire [2:0] odd_timer_overflow,
  // gate, power and oscillator status
  input  wire       gate_active,
  input  wire       sleep,
  input  wire       secondary_osc_ready,
  // outputs
  output reg        secondary_osc_enable,
  output reg        overflow_pulse,
  output reg        overflow_flag,
  output reg        wake
);

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  reg  [15:0] count_q;
  reg  [7:0]  control_q;
  reg         gate_enable_bit_q;
  reg  [3:0]  clk_sel_q;
  reg  [1:0]  instr_cnt_q;
  reg         armed_q;
  reg         run_prev_q;
  reg  [3:0]  async_prev_q;

  wire        timer_run_bit;
  wire        no_sync;
  wire [1:0]  prescale_select_field;
  wire        wr_low;
  wire        wr_high;
  wire        count_write;
  wire        instr_tick;

  assign timer_run_bit         = control_q[`CTL_RUN_BIT];
  assign no_sync               = control_q[`CTL_NOSYNC_BIT];
  assign prescale_select_field = control_q[`CTL_PS_MSB:`CTL_PS_LSB];
  assign wr_low                = reg_wr & (reg_addr == `OFS_COUNT_LOW);
  assign wr_high               = reg_wr & (reg_addr == `OFS_COUNT_HIGH);
  assign count_write           = wr_low | wr_high;

  // ---------------------------------------------------------------
  // instruction clock divider
  // ---------------------------------------------------------------
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      instr_cnt_q <= 2'h0;
    end else if (!sleep) begin
      instr_cnt_q <= instr_cnt_q + 2'h1;
    end
  end

  assign instr_tick = ~sleep & (instr_cnt_q == `INSTR_DIV);

  // ---------------------------------------------------------------
  // source edge detection
  // ---------------------------------------------------------------
  // external edge sources, synchronised path
  wire [3:0] ext_raw;
  wire [3:0] sync_rise;
  wire [3:0] sync_fall;
  wire [3:0] async_rise;
  wire [3:0] async_fall;

  assign ext_raw = {reference_clock_out, secondary_oscillator,
                    low_freq_internal_osc, count_input_pin};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_src
      level_sync u_sync (
        .clock     (clock),
        .rst_b     (rst_b),
        .level_in  (ext_raw[gi]),
        // only the edges are used, the level is left open
        .level_out (),
        .rise      (sync_rise[gi]),
        .fall      (sync_fall[gi])
      );
      // bypass path edges straight off the input
      assign async_rise[gi] = ext_raw[gi] & ~async_prev_q[gi];
      assign async_fall[gi] = ~ext_raw[gi] & async_prev_q[gi];
    end
  endgenerate

  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      async_prev_q <= 4'h0;
    end else begin
      async_prev_q <= ext_raw;
    end
  end

  // other oscillator edges on the bypass path
  reg  hf_prev_q;
  reg  mf_prev_q;
  wire hf_rise;
  wire mf_rise;

  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      hf_prev_q <= 1'b0;
      mf_prev_q <= 1'b0;
    end else begin
      hf_prev_q <= high_freq_internal_osc;
      mf_prev_q <= mid_freq_internal_osc;
    end
  end

  assign hf_rise = high_freq_internal_osc & ~hf_prev_q;
  assign mf_rise = mid_freq_internal_osc & ~mf_prev_q;

  // ---------------------------------------------------------------
  // source select
  // ---------------------------------------------------------------
  reg src_rise;
  reg src_fall;
  reg src_edge_type;

  // select edge and note whether falling edges arm it
  always @* begin
    src_rise      = 1'b0;
    src_fall      = 1'b0;
    src_edge_type = 1'b0;
    case (clk_sel_q)
      `CS_PIN: begin
        src_rise      = no_sync ? async_rise[0] : sync_rise[0];
        src_fall      = no_sync ? async_fall[0] : sync_fall[0];
        src_edge_type = 1'b1;
      end
      `CS_INSTR: begin
        src_rise = instr_tick;
      end
      `CS_SYSOSC: begin
        src_rise = ~sleep;
      end
      `CS_HFOSC: begin
        src_rise = hf_rise;
      end
      `CS_LFOSC: begin
        src_rise = no_sync ? async_rise[1] : sync_rise[1];
      end
      `CS_MFOSC: begin
        src_rise = mf_rise;
      end
      `CS_SECOSC: begin
        src_rise = no_sync ? async_rise[2] : sync_rise[2];
      end
      `CS_REFCLK: begin
        src_rise = no_sync ? async_rise[3] : sync_rise[3];
      end
      `CS_T0OVF: begin
        src_rise = timer_zero_overflow;
      end
      `CS_ODD0OVF, `CS_ODD1OVF, `CS_ODD2OVF: begin
        // own overflow code selects nothing
        if (clk_sel_q - `CS_ODD0OVF != OWN_INDEX[3:0]) begin
          src_rise = odd_timer_overflow[clk_sel_q[1:0] - 2'h1];
        end
      end
      default: begin
        src_rise = 1'b0;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // sleep, gate and arming
  // ---------------------------------------------------------------
  wire sleep_ok;
  wire cnt_enable;
  wire run_rise;
  wire armed_tick;

  // in sleep only the bypass path of non-system sources counts
  assign sleep_ok   = ~sleep | (no_sync & (clk_sel_q != `CS_INSTR) &
                      (clk_sel_q != `CS_SYSOSC));
  assign cnt_enable = timer_run_bit & (~gate_enable_bit_q | gate_active);
  assign run_rise   = timer_run_bit & ~run_prev_q;
  // the pin source needs a falling edge first
  assign armed_tick = src_rise & (armed_q | ~src_edge_type);

  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      run_prev_q <= 1'b0;
      armed_q    <= 1'b0;
    end else begin
      run_prev_q <= timer_run_bit;
      if (count_write | run_rise | ~timer_run_bit) begin
        armed_q <= 1'b0;
      end else if (src_fall) begin
        armed_q <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // prescaler
  // ---------------------------------------------------------------
  wire pre_tick;

  prescaler #(
    .WIDTH (3)
  ) u_prescaler (
    .clock     (clock),
    .rst_b     (rst_b),
    .clear     (count_write),
    .ratio_sel (prescale_select_field),
    .tick_in   (armed_tick & cnt_enable & sleep_ok),
    .tick_out  (pre_tick)
  );

  // ---------------------------------------------------------------
  // counter and overflow
  // ---------------------------------------------------------------
  wire wrap;

  assign wrap = pre_tick & (count_q == 16'hffff) & ~count_write;

  // write wins over a same-cycle increment
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      count_q <= `RST_COUNT;
    end else if (wr_low) begin
      count_q[7:0] <= reg_wdata;
    end else if (wr_high) begin
      count_q[15:8] <= reg_wdata;
    end else if (pre_tick) begin
      count_q <= count_q + 16'h0001;
    end
  end

  wire flag_clr;

  assign flag_clr = reg_wr & (reg_addr == `OFS_FLAGS) & reg_wdata[`FLG_OVF_BIT];

  // overflow flag, set beats clear
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      overflow_flag  <= 1'b0;
      overflow_pulse <= 1'b0;
      wake           <= 1'b0;
    end else begin
      overflow_pulse <= wrap;
      wake           <= wrap & sleep;
      if (wrap) begin
        overflow_flag <= 1'b1;
      end else if (flag_clr) begin
        overflow_flag <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // register writes
  // ---------------------------------------------------------------
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      control_q            <= `RST_BYTE;
      gate_enable_bit_q    <= 1'b0;
      clk_sel_q            <= `CS_PIN;
      secondary_osc_enable <= 1'b0;
    end else if (reg_wr) begin
      case (reg_addr)
        `OFS_CONTROL: begin
          control_q <= reg_wdata;
        end
        `OFS_GATE_CTRL: begin
          gate_enable_bit_q <= reg_wdata[`GATE_EN_BIT];
        end
        `OFS_CLK_SELECT: begin
          clk_sel_q <= reg_wdata[3:0];
        end
        `OFS_OSC_ENABLE: begin
          secondary_osc_enable <= reg_wdata[`OSC_SEC_EN_BIT];
        end
        default: begin
          control_q <= control_q;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // register reads, one cycle later
  // ---------------------------------------------------------------
  reg [7:0] rd_mux;

  // counter lives in this clock domain, but no high byte is buffered, so a low/high read pair can tear on a carry
  always @* begin
    rd_mux = 8'h00;
    case (reg_addr)
      `OFS_COUNT_LOW:  rd_mux = count_q[7:0];
      `OFS_COUNT_HIGH: rd_mux = count_q[15:8];
      `OFS_CONTROL:    rd_mux = control_q;
      `OFS_GATE_CTRL: begin
        rd_mux[`GATE_EN_BIT]  = gate_enable_bit_q;
        rd_mux[`GATE_VAL_BIT] = gate_active;
      end
      `OFS_CLK_SELECT: rd_mux = {4'h0, clk_sel_q};
      `OFS_OSC_ENABLE: rd_mux[`OSC_SEC_EN_BIT] = secondary_osc_enable;
      `OFS_OSC_STATUS: rd_mux[`OSC_SEC_RDY_BIT] = secondary_osc_ready;
      `OFS_FLAGS:      rd_mux[`FLG_OVF_BIT] = overflow_flag;
      default:         rd_mux = 8'h00;
    endcase
  end

  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rd_mux;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule // gated_timer_counter_core

// >>> timer_consts.vh
// register offsets, field positions and reset values of the gated timer counter
`ifndef TIMER_CONSTS_VH
`define TIMER_CONSTS_VH

// register offsets
`define OFS_COUNT_LOW   3'h0
`define OFS_COUNT_HIGH  3'h1
`define OFS_CONTROL     3'h2
`define OFS_GATE_CTRL   3'h3
`define OFS_CLK_SELECT  3'h4
`define OFS_OSC_ENABLE  3'h5
`define OFS_OSC_STATUS  3'h6
`define OFS_FLAGS       3'h7

// control register fields
`define CTL_RUN_BIT     0
`define CTL_NOSYNC_BIT  2
`define CTL_PS_LSB      4
`define CTL_PS_MSB      5
// gate control fields
`define GATE_EN_BIT     7
`define GATE_VAL_BIT    2
// oscillator enable and status fields
`define OSC_SEC_EN_BIT  3
`define OSC_SEC_RDY_BIT 4
// flag register fields
`define FLG_OVF_BIT     0

// clock select codes
`define CS_PIN          4'h0
`define CS_INSTR        4'h1
`define CS_SYSOSC       4'h2
`define CS_HFOSC        4'h3
`define CS_LFOSC        4'h4
`define CS_MFOSC        4'h5
`define CS_SECOSC       4'h6
`define CS_REFCLK       4'h7
`define CS_T0OVF        4'h8
`define CS_ODD0OVF      4'h9
`define CS_ODD1OVF      4'ha
`define CS_ODD2OVF      4'hb

// reset values
`define RST_COUNT       16'h0000
`define RST_BYTE        8'h00

// last count of the four-clock instruction cycle
`define INSTR_DIV       2'h3

`endif

// >>> level_sync.v
// two-flop synchroniser with rising and falling edge outputs
`timescale 1ns/10ps
module level_sync (
  // clock and reset
  input  wire clock,
  input  wire rst_b,
  // raw level and its synchronised edges
  input  wire level_in,
  output wire level_out,
  output wire rise,
  output wire fall
);

  reg meta_q;
  reg sync_q;
  reg prev_q;

  // first flop feeds only the second
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      meta_q <= level_in;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign level_out = sync_q;
  assign rise      = sync_q & ~prev_q;
  assign fall      = ~sync_q & prev_q;

endmodule // level_sync

// >>> prescaler.v
// hidden prescale counter dividing source ticks by 1, 2, 4 or 8
`timescale 1ns/10ps
module prescaler #(
  parameter WIDTH = 3
) (
  // clock and reset
  input  wire       clock,
  input  wire       rst_b,
  // control
  input  wire       clear,
  input  wire [1:0] ratio_sel,
  // ticks in and divided ticks out
  input  wire       tick_in,
  output wire       tick_out
);

  reg  [WIDTH-1:0] cnt_q;
  wire [WIDTH-1:0] mask;

  // low bits that must be all ones for a pulse
  assign mask     = (({{(WIDTH-1){1'b0}}, 1'b1} << ratio_sel) - {{(WIDTH-1){1'b0}}, 1'b1});
  assign tick_out = tick_in & ((cnt_q & mask) == mask);

  // counter is never visible to software
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= {WIDTH{1'b0}};
    end else if (clear) begin
      cnt_q <= {WIDTH{1'b0}};
    end else if (tick_in) begin
      cnt_q <= cnt_q + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

endmodule // prescaler

// >>> timer_chk_sva.sv
// port assertions for the gated timer counter core
`timescale 1ns/10ps
`include "timer_consts.vh"
module timer_chk (
  // clock and reset
  input wire       clock,
  input wire       rst_b,
  // register port
  input wire [2:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire       reg_wr,
  input wire       reg_rd,
  input wire [7:0] reg_rdata,
  // power and status
  input wire       sleep,
  input wire       secondary_osc_enable,
  input wire       overflow_pulse,
  input wire       overflow_flag,
  input wire       wake
);
  // ---------------------------------------------
  // shadow of the clock select field
  // ---------------------------------------------
  reg  [3:0] sel_q;
  wire       clr_w = reg_wr && reg_addr == `OFS_FLAGS && reg_wdata[`FLG_OVF_BIT];
  wire       osc_w = reg_wr && reg_addr == `OFS_OSC_ENABLE;
  always @(posedge clock or negedge rst_b)
    if (!rst_b)
      sel_q <= 4'h0;
    else if (reg_wr && reg_addr == `OFS_CLK_SELECT)
      sel_q <= reg_wdata[3:0];

  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);

  AST_RD_IDLE: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside read cycle");
  AST_SEL_READ: assert property (reg_rd && reg_addr == `OFS_CLK_SELECT |=> reg_rdata == {4'h0, sel_q})
    else $error("clock select read back wrong");
  AST_OVF_ONE: assert property (overflow_pulse |=> !overflow_pulse)
    else $error("overflow pulse too long");
  AST_FLAG_SET: assert property (overflow_pulse |-> overflow_flag)
    else $error("flag not set with overflow");
  AST_FLAG_ROSE: assert property ($rose(overflow_flag) |-> overflow_pulse)
    else $error("flag set without overflow");
  AST_FLAG_CLR: assert property (clr_w |=> overflow_flag == overflow_pulse)
    else $error("flag clear wrong");
  AST_FLAG_HOLD: assert property (overflow_flag && !clr_w |=> overflow_flag)
    else $error("flag lost");
  AST_WAKE: assert property (wake |-> overflow_pulse && $past(sleep))
    else $error("wake without sleeping overflow");
  AST_OSC_SET: assert property (osc_w |=> secondary_osc_enable == $past(reg_wdata[`OSC_SEC_EN_BIT]))
    else $error("oscillator enable not written");
  AST_OSC_HOLD: assert property (!osc_w |=> $stable(secondary_osc_enable))
    else $error("oscillator enable moved");
endmodule // timer_chk

bind gated_timer_counter_core timer_chk u_chk (.clock, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .sleep, .secondary_osc_enable, .overflow_pulse, .overflow_flag, .wake);

// >>> src_model.sv
// far-side count sources: pin, oscillators, reference and secondary oscillator
`timescale 1ns/10ps
module src_model #(
  parameter READY_DLY = 20
) (
  // clock and reset
  input  wire       clock,
  input  wire       rst_b,
  // burst request and oscillator enable
  input  wire       burst,
  input  wire       secondary_osc_enable,
  // pin, hf, lf, mf, secondary, reference levels
  output wire [5:0] lvl,
  output wire       secondary_osc_ready
);
  reg [6:0] cnt_q;
  reg       act_q;
  reg [5:0] dly_q;
  genvar    i;
  // burst phase; all sources stand low outside a burst
  always @(posedge clock or negedge rst_b)
    if (!rst_b) begin
      cnt_q <= 7'h00;
      act_q <= 1'b0;
    end else if (burst) begin
      cnt_q <= 7'h00;
      act_q <= 1'b1;
    end else if (act_q) begin
      cnt_q <= cnt_q + 7'h01;
      act_q <= cnt_q != 7'h3f;
    end
  // source i gives i+2 rising edges, eight clocks apart
  generate
    for (i = 0; i < 6; i = i + 1) begin : g_src
      assign lvl[i] = act_q && cnt_q[2] && cnt_q[6:3] < i + 2 && (i != 4 || secondary_osc_enable);
    end
  endgenerate
  // ready only after a start-up delay
  always @(posedge clock or negedge rst_b)
    if (!rst_b || !secondary_osc_enable)
      dly_q <= 6'h00;
    else if (dly_q != READY_DLY)
      dly_q <= dly_q + 6'h01;
  assign secondary_osc_ready = dly_q == READY_DLY;
endmodule // src_model

// >>> gated_timer_counter_core_tb_top.sv
// self-checking bench of the gated timer counter core
`timescale 1ns/10ps
`include "timer_consts.vh"
`define CHK(g, x) begin samples_checked++; if ((g) !== (x)) begin fails++; \
  $display("[ERR] %0t got %h want %h", $time, g, x); end end
module gated_timer_counter_core_tb_top;
  reg        clock, rst_b, reg_wr, reg_rd, timer_zero_overflow, gate_active, sleep, burst, rd_q;
  reg  [2:0] reg_addr, odd_timer_overflow;
  reg  [7:0] reg_wdata;
  reg  [15:0] e;
  reg  [31:0] rnd_q;
  wire [7:0] reg_rdata;
  wire [5:0] lvl;
  wire       secondary_osc_ready, secondary_osc_enable, overflow_pulse, overflow_flag, wake;
  int        fails, samples_checked, ovf_n, wake_n, i, c, p, m, k;
  logic [15:0] exp_q[$];

  gated_timer_counter_core dut (.clock, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .count_input_pin(lvl[0]), .high_freq_internal_osc(lvl[1]), .low_freq_internal_osc(lvl[2]),
    .mid_freq_internal_osc(lvl[3]), .secondary_oscillator(lvl[4]), .reference_clock_out(lvl[5]),
    .timer_zero_overflow, .odd_timer_overflow, .gate_active, .sleep, .secondary_osc_ready,
    .secondary_osc_enable, .overflow_pulse, .overflow_flag, .wake);
  src_model u_src (.clock, .rst_b, .burst, .secondary_osc_enable, .lvl, .secondary_osc_ready);

  always #2 clock = ~clock;

  function [31:0] xs(input [31:0] s);
    reg [31:0] t;
    begin
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction
  // mask and value expected per clock select code
  function [15:0] exp_of(input [3:0] cs);
    case (cs)
      4'h0: exp_of = 16'hff01;
      4'h1: exp_of = 16'hf810;
      4'h2: exp_of = 16'hf840;
      4'h8: exp_of = 16'hff01;
      4'ha: exp_of = 16'hff03;
      4'hb: exp_of = 16'hff04;
      default: exp_of = cs < 4'h8 ? {12'hff0, cs} : 16'hff00;
    endcase
  endfunction
  task wr(input [2:0] a, input [7:0] d);
    begin
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
    end
  endtask
  task rd(input [2:0] a, input [15:0] x);
    begin
      exp_q.push_back(x);
      @(posedge clock);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
    end
  endtask
  task tz(input int n);
    begin
      repeat (n) begin
        @(posedge clock);
        timer_zero_overflow <= 1'b1;
        @(posedge clock);
        timer_zero_overflow <= 1'b0;
      end
      repeat (4) @(posedge clock);
    end
  endtask
  task test_done;
    begin
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask

  // ---------------------------------------------
  // result watcher
  // ---------------------------------------------
  always @(posedge clock) begin
    if (rd_q) begin
      e = exp_q.pop_front();
      `CHK(reg_rdata & e[15:8], e[7:0])
    end
    rd_q <= reg_rd;
    ovf_n += overflow_pulse;
    wake_n += wake;
  end

  initial begin
    repeat (60000) @(posedge clock);
    fails++;
    test_done;
  end

  initial begin
    {clock, rst_b, reg_wr, reg_rd, timer_zero_overflow, gate_active, sleep, burst} = 8'h00;
    {reg_addr, odd_timer_overflow, reg_wdata} = 14'h0000;
    rnd_q = 32'hbc96;
    repeat (2) @(posedge clock);
    rst_b <= 1'b1;
    for (i = 0; i < 8; i++) rd(i[2:0], 16'hff00);
    rnd_q = xs(rnd_q);
    wr(`OFS_COUNT_LOW, rnd_q[7:0]);
    wr(`OFS_COUNT_HIGH, rnd_q[15:8]);
    wr(`OFS_CLK_SELECT, rnd_q[23:16]);
    rd(`OFS_COUNT_LOW, {8'hff, rnd_q[7:0]});
    rd(`OFS_COUNT_HIGH, {8'hff, rnd_q[15:8]});
    rd(`OFS_CLK_SELECT, {12'hff0, rnd_q[19:16]});
    $display("test registers done");
    wr(`OFS_OSC_ENABLE, 8'h08);
    for (i = 0; i < 100 && secondary_osc_ready !== 1'b1; i++) @(posedge clock);
    if (i == 100) begin
      fails++;
      test_done;
    end
    rd(`OFS_OSC_STATUS, 16'hff10);
    for (c = 0; c < 16; c++) begin
      rnd_q = xs(rnd_q);
      wr(`OFS_CONTROL, 8'h00);
      wr(`OFS_CLK_SELECT, c[7:0]);
      wr(`OFS_COUNT_LOW, 8'h00);
      wr(`OFS_COUNT_HIGH, 8'h00);
      wr(`OFS_CONTROL, {5'h00, rnd_q[0], 2'h1});
      burst <= 1'b1;
      for (k = 0; k < 4; k++) begin
        @(posedge clock);
        burst <= 1'b0;
        timer_zero_overflow <= k < 1;
        odd_timer_overflow <= {k < 4, k < 3, k < 2};
        @(posedge clock);
        timer_zero_overflow <= 1'b0;
        odd_timer_overflow <= 3'h0;
      end
      repeat (58) @(posedge clock);
      wr(`OFS_CONTROL, 8'h00);
      rd(`OFS_COUNT_LOW, exp_of(c[3:0]));
    end
    $display("test sources done");
    wr(`OFS_CLK_SELECT, 8'h08);
    for (p = 0; p < 4; p++) begin
      wr(`OFS_CONTROL, 8'h00);
      wr(`OFS_COUNT_LOW, 8'h00);
      wr(`OFS_CONTROL, {2'h0, p[1:0], 4'h1});
      tz(16);
      rd(`OFS_COUNT_LOW, {8'hff, 8'h10 >> p});
    end
    tz(5);
    wr(`OFS_COUNT_LOW, 8'h00);
    tz(7);
    rd(`OFS_COUNT_LOW, 16'hff00);
    $display("test prescaler done");
    wr(`OFS_CONTROL, 8'h01);
    wr(`OFS_GATE_CTRL, 8'h80);
    tz(3);
    rd(`OFS_COUNT_LOW, 16'hff00);
    gate_active <= 1'b1;
    tz(3);
    rd(`OFS_GATE_CTRL, 16'hff84);
    rd(`OFS_COUNT_LOW, 16'hff03);
    wr(`OFS_CONTROL, 8'h00);
    tz(3);
    rd(`OFS_COUNT_LOW, 16'hff03);
    wr(`OFS_GATE_CTRL, 8'h00);
    $display("test gate done");
    wr(`OFS_CONTROL, 8'h01);
    wr(`OFS_COUNT_HIGH, 8'hff);
    wr(`OFS_COUNT_LOW, 8'hff);
    tz(1);
    rd(`OFS_COUNT_HIGH, 16'hff00);
    rd(`OFS_FLAGS, 16'hff01);
    `CHK(ovf_n, 1)
    wr(`OFS_FLAGS, 8'h01);
    rd(`OFS_FLAGS, 16'hff00);
    $display("test overflow done");
    sleep <= 1'b1;
    for (m = 0; m < 2; m++) begin
      wr(`OFS_CONTROL, 8'h00);
      wr(`OFS_CLK_SELECT, 8'h00);
      wr(`OFS_COUNT_HIGH, 8'hff);
      wr(`OFS_COUNT_LOW, 8'hff);
      wr(`OFS_CONTROL, m ? 8'h01 : 8'h05);
      burst <= 1'b1;
      @(posedge clock);
      burst <= 1'b0;
      rd(`OFS_COUNT_HIGH, 16'hffff);
      repeat (70) @(posedge clock);
      rd(`OFS_COUNT_LOW, m ? 16'hffff : 16'hff00);
    end
    `CHK(wake_n, 1)
    sleep <= 1'b0;
    $display("test sleep done");
    repeat (4) @(posedge clock);
    `CHK(exp_q.size(), 0)
    test_done;
  end
endmodule // gated_timer_counter_core_tb_top
